// *** data_memory_pkg.sv ***
package data_memory_pkg;

    // Data memory shape.
    localparam int unsigned GP_DEPTH   = 128;
    localparam int unsigned PC_WIDTH   = 11;

    // Special-purpose register locations in the core's data space.
    localparam logic [7:0] ADDR_IAR_LOW  = 8'h00;
    localparam logic [7:0] ADDR_PTR_LOW  = 8'h01;
    localparam logic [7:0] ADDR_IAR_ANY  = 8'h02;
    localparam logic [7:0] ADDR_PTR_ANY  = 8'h03;
    localparam logic [7:0] ADDR_BANK_SEL = 8'h04;
    localparam logic [7:0] ADDR_ACC      = 8'h05;
    localparam logic [7:0] ADDR_PC_LOW   = 8'h06;
    localparam logic [7:0] ADDR_PC_HIGH  = 8'h07;
    localparam logic [7:0] ADDR_NVM_CTRL = 8'h40;
    localparam logic [7:0] ADDR_GP_BASE  = 8'h80;

    // Reset values.
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic       RST_BANK      = 1'b0;
    localparam logic [3:0] RST_NVM_CTRL  = 4'h0;
    localparam logic [PC_WIDTH-1:0] RST_PC = 11'h000;
    localparam logic [7:0] UNUSED_VALUE  = 8'h00;

    // Software register map on the AXI4-Lite slave.
    localparam logic [31:0] AXI_BANK_SEL = 32'h0000_0000;
    localparam logic [31:0] AXI_ACC      = 32'h0000_0004;
    localparam logic [31:0] AXI_PC       = 32'h0000_0008;
    localparam logic [31:0] AXI_NVM_CTRL = 32'h0000_000C;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_DECERR  = 2'h3;

    // Bit-manipulation operation codes.
    typedef enum logic [1:0] {
        BITOP_NONE  = 2'h0,
        BITOP_SET   = 2'h1,
        BITOP_CLEAR = 2'h2
    } bitop_t;

endpackage

// *** banked_data_memory.sv ***
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module banked_data_memory
    import data_memory_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic                mem_req,
    input  wire logic                mem_we,
    input  wire logic [1:0]          mem_bitop,
    input  wire logic [2:0]          mem_bit_sel,
    input  wire logic [7:0]          mem_addr,
    input  wire logic                mem_to_acc,
    input  wire logic                acc_load,
    input  wire logic [7:0]          acc_data,
    input  wire logic                pc_advance,
    input  wire logic                wdt_reset,
    input  wire logic                wdt_in_idle,
    output logic      [7:0]          mem_rdata,
    output logic                     mem_ack,
    output logic      [7:0]          accumulator,
    output logic      [PC_WIDTH-1:0] program_counter,
    output logic                     dummy_cycle,
    output logic                     bank_select_bit,
    output logic      [3:0]          nvm_control,
    input  wire logic [31:0]         s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic      [1:0]          s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [31:0]         s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic      [31:0]         s_axi_rdata,
    output logic      [1:0]          s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);

    logic                rst_meta_q;
    logic                rst_n_q;
    logic [7:0]          ram_q [GP_DEPTH];
    logic [7:0]          ptr_low_q;
    logic [7:0]          ptr_any_q;
    logic                bank_q;
    logic [7:0]          acc_q;
    logic [PC_WIDTH-1:0] pc_q;
    logic                dummy_q;
    logic [3:0]          nvm_q;
    logic [8:0]          phys;
    logic [7:0]          rd_val;
    logic [7:0]          bit_mask;
    logic [7:0]          wr_val;
    logic                wr_en;
    logic                wr_ram;
    logic                wr_sfr;
    logic                wr_nvm;
    logic                aw_have_q;
    logic                w_have_q;
    logic [31:0]         awaddr_q;
    logic [31:0]         wdata_q;
    logic [3:0]          wstrb_q;
    logic                axi_wr;
    logic [31:0]         axi_rd_val;
    logic                axi_rd_hit;

    // Reset is released through two flip-flops.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Address resolution: the indirect ports redirect to their pointers.
    always_comb
    begin
        if (mem_addr == ADDR_IAR_LOW)
            phys = {1'b0, ptr_low_q};
        else if (mem_addr == ADDR_IAR_ANY)
            phys = {bank_q, ptr_any_q};
        else
            phys = {1'b0, mem_addr};
    end

    // Read decode of a resolved nine-bit address.
    always_comb
    begin
        rd_val = UNUSED_VALUE;
        if (phys[8])
        begin
            if (phys[7:0] == ADDR_NVM_CTRL)
                rd_val = {4'h0, nvm_q};
        end
        else if (phys[7:0] >= ADDR_GP_BASE)
            rd_val = ram_q[phys[6:0]];
        else
        begin
            case (phys[7:0])
                ADDR_PTR_LOW:  rd_val = ptr_low_q;
                ADDR_PTR_ANY:  rd_val = ptr_any_q;
                ADDR_BANK_SEL: rd_val = {7'h00, bank_q};
                ADDR_ACC:      rd_val = acc_q;
                ADDR_PC_LOW:   rd_val = pc_q[7:0];
                ADDR_PC_HIGH:  rd_val = {5'h00, pc_q[PC_WIDTH-1:8]};
                default:       rd_val = UNUSED_VALUE;
            endcase
        end
    end

    // Writes take the accumulator, or the read value with one bit changed.
    always_comb
    begin
        bit_mask = 8'h01 << mem_bit_sel;
        case (bitop_t'(mem_bitop))
            BITOP_SET:   wr_val = rd_val | bit_mask;
            BITOP_CLEAR: wr_val = rd_val & ~bit_mask;
            default:     wr_val = acc_q;
        endcase
        wr_en  = mem_req && (mem_we || mem_bitop != BITOP_NONE);
        wr_ram = wr_en && !phys[8] && phys[7:0] >= ADDR_GP_BASE;
        wr_sfr = wr_en && !phys[8] && phys[7:0] < ADDR_GP_BASE;
        wr_nvm = wr_en && phys == {1'b1, ADDR_NVM_CTRL};
    end

    // General-purpose storage, bank 0 only.
    always_ff @(posedge clk)
    begin
        if (wr_ram)
            ram_q[phys[6:0]] <= wr_val;
    end

    // Memory pointers.
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ptr_low_q <= RST_BYTE;
            ptr_any_q <= RST_BYTE;
        end
        else
        begin
            if (wr_sfr && phys[7:0] == ADDR_PTR_LOW)
                ptr_low_q <= wr_val;
            if (wr_sfr && phys[7:0] == ADDR_PTR_ANY)
                ptr_any_q <= wr_val;
        end
    end

    // Bank selection; the watchdog reset leaves it alone when idle.
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            bank_q <= RST_BANK;
        else if (wdt_reset)
        begin
            if (!wdt_in_idle)
                bank_q <= RST_BANK;
        end
        else if (wr_sfr && phys[7:0] == ADDR_BANK_SEL)
            bank_q <= wr_val[0];
        else if (axi_wr && awaddr_q == AXI_BANK_SEL && wstrb_q[0])
            bank_q <= wdata_q[0];
    end

    // Accumulator: ALU results have priority over register writes.
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            acc_q <= RST_BYTE;
        else if (acc_load)
            acc_q <= acc_data;
        else if (wr_sfr && phys[7:0] == ADDR_ACC)
            acc_q <= wr_val;
        else if (mem_req && !wr_en && mem_to_acc)
            acc_q <= rd_val;
    end

    // Program counter; the high byte is read-only.
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pc_q    <= RST_PC;
            dummy_q <= 1'b0;
        end
        else if (wr_sfr && phys[7:0] == ADDR_PC_LOW)
        begin
            pc_q[7:0] <= wr_val;
            dummy_q   <= 1'b1;
        end
        else
        begin
            dummy_q <= 1'b0;
            if (pc_advance && !dummy_q)
                pc_q <= pc_q + 11'h001;
        end
    end

    // Non-volatile memory control register; the core reaches it in bank 1 only, the AXI4-Lite slave reads it in either bank.
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            nvm_q <= RST_NVM_CTRL;
        else if (wr_nvm)
            nvm_q <= wr_val[3:0];
    end

    // Core answer, one cycle after the request.
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            mem_rdata <= RST_BYTE;
            mem_ack   <= 1'b0;
        end
        else
        begin
            mem_ack <= mem_req;
            if (mem_req)
                mem_rdata <= rd_val;
        end
    end

    assign accumulator     = acc_q;
    assign program_counter = pc_q;
    assign dummy_cycle     = dummy_q;
    assign bank_select_bit = bank_q;
    assign nvm_control     = nvm_q;

    // AXI4-Lite write channel; address and data are taken in either order.
    assign axi_wr = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= 32'h0000_0000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (axi_wr)
            begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_q == AXI_BANK_SEL) ? RESP_OKAY : RESP_DECERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel.
    always_comb
    begin
        axi_rd_hit = 1'b1;
        case (s_axi_araddr)
            AXI_BANK_SEL: axi_rd_val = {31'h0000_0000, bank_q};
            AXI_ACC:      axi_rd_val = {24'h00_0000, acc_q};
            AXI_PC:       axi_rd_val = {21'h00_0000, pc_q};
            AXI_NVM_CTRL: axi_rd_val = {28'h000_0000, nvm_q};
            default:
            begin
                axi_rd_val = 32'h0000_0000;
                axi_rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= axi_rd_val;
            s_axi_rresp   <= axi_rd_hit ? RESP_OKAY : RESP_DECERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    AST_INDIRECT_LOW_BANK0: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        mem_req && !mem_we && mem_bitop == BITOP_NONE && mem_addr == ADDR_IAR_LOW
        && ptr_low_q >= ADDR_GP_BASE |=> mem_rdata == $past(ram_q[ptr_low_q[6:0]]))
        else $error("Low indirect port left bank 0.");

    AST_INDIRECT_ANY_ADDR: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        mem_req && !mem_we && mem_bitop == BITOP_NONE && mem_addr == ADDR_IAR_ANY
        && bank_q && ptr_any_q == ADDR_NVM_CTRL |=> mem_rdata == {4'h0, $past(nvm_q)})
        else $error("Any-bank indirect address is wrong.");

    AST_DIRECT_BANK0: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        mem_req && !mem_we && mem_bitop == BITOP_NONE && mem_addr == ADDR_NVM_CTRL
        |=> mem_rdata == UNUSED_VALUE)
        else $error("Direct access reached bank 1.");

    AST_UNUSED_READS_ZERO: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        mem_req && !phys[8] && phys[7:0] > ADDR_PC_HIGH && phys[7:0] < ADDR_GP_BASE
        |=> mem_ack && mem_rdata == 8'h00)
        else $error("Unused location did not read 00H.");

    AST_BANK_UPPER_ZERO: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        mem_req && phys == {1'b0, ADDR_BANK_SEL} |=> mem_rdata[7:1] == 7'h00)
        else $error("Bank-select upper bits not zero.");

    AST_WDT_RUN_CLEARS_BANK: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        wdt_reset && !wdt_in_idle |=> bank_q == RST_BANK)
        else $error("Watchdog reset did not clear bank.");

    AST_WDT_IDLE_KEEPS_BANK: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        wdt_reset && wdt_in_idle |=> $stable(bank_q))
        else $error("Idle watchdog reset changed bank.");

    AST_PCL_JUMP_IN_PAGE: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        wr_sfr && phys[7:0] == ADDR_PC_LOW
        |=> pc_q[PC_WIDTH-1:8] == $past(pc_q[PC_WIDTH-1:8]) && pc_q[7:0] == $past(wr_val))
        else $error("Program-counter-low write left the page.");

    AST_PCL_DUMMY: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        wr_sfr && phys[7:0] == ADDR_PC_LOW ##1 !(wr_sfr && phys[7:0] == ADDR_PC_LOW)
        |-> dummy_q ##1 (!dummy_q && $stable(pc_q)))
        else $error("Jump dummy cycle missing.");

    AST_BIT_SET: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        wr_ram && mem_bitop == BITOP_SET
        |=> ram_q[$past(phys[6:0])] == ($past(rd_val) | $past(bit_mask)))
        else $error("Bit set disturbed other bits.");

    AST_ACC_LOAD: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        acc_load |=> acc_q == $past(acc_data))
        else $error("Accumulator missed a result.");

endmodule

// *** core_model.sv ***
`timescale 1ns/1ps
module core_model
    import data_memory_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       mem_ack,
    input  wire logic [7:0] mem_rdata,
    input  wire logic       dummy_cycle,
    output logic            mem_req,
    output logic            mem_we,
    output logic      [1:0] mem_bitop,
    output logic      [2:0] mem_bit_sel,
    output logic      [7:0] mem_addr,
    output logic            mem_to_acc,
    output logic            acc_load,
    output logic      [7:0] acc_data,
    output logic            pc_advance
);
    // Released address, bit-select and data lines show the inverse of their last value; control lines return to 0.
    initial
    begin
        {mem_req, mem_we, mem_to_acc, acc_load, pc_advance} = '0;
        mem_bitop = BITOP_NONE;
        mem_bit_sel = 3'h7;
        mem_addr = 8'hFF;
        acc_data = 8'hFF;
    end

    task automatic load_acc(input logic [7:0] v);
        @(posedge clk);
        acc_load <= 1'b1;
        acc_data <= v;
        @(posedge clk);
        acc_load <= 1'b0;
        acc_data <= ~v;
    endtask

    task automatic advance(input int n);
        @(posedge clk);
        pc_advance <= 1'b1;
        repeat (n) @(posedge clk);
        pc_advance <= 1'b0;
    endtask

    task automatic access(input logic [7:0] a, input logic we, input bitop_t op,
                          input logic [2:0] b, input logic to_acc,
                          output logic [7:0] rd, output logic dm);
        int n;
        @(posedge clk);
        mem_req <= 1'b1;
        mem_addr <= a;
        mem_we <= we;
        mem_bitop <= op;
        mem_bit_sel <= b;
        mem_to_acc <= to_acc;
        @(posedge clk);
        mem_req <= 1'b0;
        mem_addr <= ~a;
        mem_we <= 1'b0;
        mem_bitop <= BITOP_NONE;
        mem_bit_sel <= ~b;
        mem_to_acc <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (mem_ack !== 1'b1 && n < 8);
        rd = mem_rdata;
        // An answer that never came leaves an unknown for the bench to count.
        dm = (mem_ack === 1'b1) ? dummy_cycle : 1'bx;
    endtask
endmodule

// *** banked_data_memory_test.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module banked_data_memory_test
    import data_memory_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_t;
    localparam row_t ROWS [9] = '{'{8'h80, 8'h5A, 8'h5A}, '{8'hFF, 8'hA5, 8'hA5},
        '{8'h01, 8'h3C, 8'h3C}, '{8'h03, 8'h81, 8'h81}, '{8'h04, 8'hFF, 8'h01},
        '{8'h04, 8'h00, 8'h00}, '{8'h10, 8'hFF, 8'h00}, '{8'h7F, 8'h55, 8'h00},
        '{8'h40, 8'hAA, 8'h00}};
    logic                clk = 0;
    logic                reset_n = 0;
    logic                wdt_reset = 0;
    logic                wdt_in_idle = 0;
    logic                mem_req, mem_we, mem_to_acc, acc_load, pc_advance;
    logic [1:0]          mem_bitop;
    logic [2:0]          mem_bit_sel;
    logic [7:0]          mem_addr, acc_data, mem_rdata, accumulator;
    logic                mem_ack, dummy_cycle, bank_select_bit;
    logic [PC_WIDTH-1:0] program_counter;
    logic [3:0]          nvm_control;
    logic [31:0]         s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [3:0]          s_axi_wstrb = 0;
    logic                s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic                s_axi_arvalid = 0, s_axi_rready = 0;
    logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic                s_axi_rvalid;
    logic [1:0]          s_axi_bresp, s_axi_rresp, r;
    logic [7:0]          v;
    logic [31:0]         d;
    logic                dm;
    int                  n_mismatch = 0;
    int                  total_checks = 0;

    always #12.5 clk = ~clk;

    banked_data_memory uut (.clk, .reset_n, .mem_req, .mem_we, .mem_bitop, .mem_bit_sel,
        .mem_addr, .mem_to_acc, .acc_load, .acc_data, .pc_advance, .wdt_reset, .wdt_in_idle,
        .mem_rdata, .mem_ack, .accumulator, .program_counter, .dummy_cycle, .bank_select_bit,
        .nvm_control, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    core_model core (.clk, .mem_ack, .mem_rdata, .dummy_cycle, .mem_req, .mem_we, .mem_bitop,
        .mem_bit_sel, .mem_addr, .mem_to_acc, .acc_load, .acc_data, .pc_advance);

    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] t;
        core.load_acc(x);
        core.access(a, 1'b1, BITOP_NONE, 3'h0, 1'b0, t, dm);
        if (dm === 1'bx)
            n_mismatch++;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        core.access(a, 1'b0, BITOP_NONE, 3'h0, 1'b0, x, dm);
        if (dm === 1'bx)
            n_mismatch++;
    endtask

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] x, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= x;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        if (s_axi_bvalid !== 1'b1)
            n_mismatch++;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [31:0] a);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        if (s_axi_rvalid !== 1'b1)
            n_mismatch++;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic pulse_wdt(input logic idle);
        @(posedge clk);
        wdt_in_idle <= idle;
        wdt_reset <= 1'b1;
        @(posedge clk);
        wdt_reset <= 1'b0;
        @(posedge clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #(25 * 6000);
        n_mismatch++;
        tally_and_finish();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(bank_select_bit, 1'b0)
        `CHK(program_counter, RST_PC)
        axi_rd(AXI_BANK_SEL);
        `CHK(d, 32'h0000_0000)
        $display("reset values done");
        foreach (ROWS[i])
        begin
            wr(ROWS[i].a, ROWS[i].w);
            rd(ROWS[i].a, v);
            `CHK(v, ROWS[i].e)
        end
        $display("row table done");
        core.access(8'h80, 1'b0, BITOP_SET, 3'h0, 1'b0, v, dm);
        core.access(8'h80, 1'b0, BITOP_CLEAR, 3'h6, 1'b0, v, dm);
        rd(8'h80, v);
        `CHK(v, 8'h1B)
        $display("bit operations done");
        wr(8'h01, 8'h82);
        wr(8'h00, 8'h77);
        rd(8'h82, v);
        `CHK(v, 8'h77)
        wr(8'h01, 8'h00);
        rd(8'h00, v);
        `CHK(v, 8'h00)
        $display("indirect low done");
        wr(8'h04, 8'h01);
        `CHK(bank_select_bit, 1'b1)
        wr(8'h03, 8'h40);
        wr(8'h02, 8'h0F);
        `CHK(nvm_control, 4'hF)
        rd(8'h02, v);
        `CHK(v, 8'h0F)
        wr(8'h80, 8'hC3);
        wr(8'h03, 8'h80);
        rd(8'h02, v);
        `CHK(v, 8'h00)
        wr(8'h01, 8'h80);
        rd(8'h00, v);
        `CHK(v, 8'hC3)
        rd(8'h40, v);
        `CHK(v, 8'h00)
        $display("bank select done");
        core.access(8'h82, 1'b0, BITOP_NONE, 3'h0, 1'b1, v, dm);
        `CHK(accumulator, 8'h77)
        pulse_wdt(1'b1);
        `CHK(bank_select_bit, 1'b1)
        pulse_wdt(1'b0);
        `CHK(bank_select_bit, 1'b0)
        $display("accumulator and watchdog done");
        core.advance(300);
        wr(8'h06, 8'h20);
        `CHK(dm, 1'b1)
        `CHK(program_counter, 11'h120)
        wr(8'h07, 8'hFF);
        rd(8'h07, v);
        `CHK(v, 8'h01)
        $display("program counter done");
        axi_wr(AXI_BANK_SEL, 32'h0000_0001, 4'hF);
        `CHK(r, RESP_OKAY)
        axi_wr(AXI_BANK_SEL, 32'h0000_0000, 4'h0);
        `CHK(bank_select_bit, 1'b1)
        axi_wr(AXI_PC, 32'h0000_0000, 4'hF);
        `CHK(r, RESP_DECERR)
        axi_rd(AXI_ACC);
        `CHK(d, 32'h0000_00FF)
        axi_rd(AXI_NVM_CTRL);
        `CHK(d, 32'h0000_000F)
        axi_rd(32'h0000_0010);
        `CHK(r, RESP_DECERR)
        `CHK(d, 32'h0000_0000)
        $display("register bus done");
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(bank_select_bit, 1'b0)
        `CHK(accumulator, 8'h00)
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h01, v);
        `CHK(v, 8'h00)
        $display("second reset done");
        tally_and_finish();
    end
endmodule
